// File: core/admcr_regs.sv
// Summary of operation
// - top word bit one reads, zero writes
// - registers 22 and 23 ignore writes
// - bits 14..8 index, 7..0 data
// - left/right codes reset to all ones
// - gain is half dB times code-255
// - codes zero to fourteen mean full mute
// - load bit gates new attenuation codes
// - three-bit format select, reset 101
// - de-emphasis rate field, reset disabled
// - one-bit mode reuses rate for FIR
// - de-emphasis enable for both channels
// - soft mute bit for both channels
// - soft mute ramps 255 steps
// - polarity invert bit for both outputs
// - step every 1,2,4,8 frames
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module admcr_regs #(
  parameter int ADDR_W = 8,
  parameter logic [4:0] DEVICE_NUMBER = 5'h05 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_clk_pin,
  input wire logic zero_left_pin,
  input wire logic zero_right_pin,
  output logic [7:0] left_applied_level,
  output logic [7:0] right_applied_level,
  output logic left_full_mute,
  output logic right_full_mute,
  output var admcr_pkg::admcr_mode_t mode_out
);
  // elaboration check: the decoder needs eight address bits
  if (ADDR_W < 8)
  begin : gen_addr_check
    $error("admcr_regs: ADDR_W below 8");
  end

  // bus request bundle and register state
  admcr_pkg::admcr_apb_req_t req;
  logic [7:0] att_l_ff, att_r_ff, tgt_l_ff, tgt_r_ff, lvl_l_ff, lvl_r_ff;
  logic [7:0] ctl_ff, phase_ff, mode_ff, zero_ff;
  logic [15:0] cword_ff;
  logic [7:0] cword_rd_ff;
  logic [2:0] frm_sync_ff;
  logic [1:0] zl_sync_ff, zr_sync_ff;
  logic [2:0] frm_cnt_ff;
  logic [7:0] smute_ff;
  logic step;
  logic wr_en;
  logic [6:0] idx;
  logic [31:0] nxt_prdata;
  logic nxt_err;

  // gather the bus pins into one request word
  assign req = '{psel, penable, pwrite, paddr[7:0], pwdata};

  // byte address is four times the register index
  function automatic logic [6:0] word_index(input logic [7:0] a);
    word_index = {1'b0, a[7:2]};
  endfunction

  // true for any mapped index
  function automatic logic mapped(input logic [6:0] i);
    mapped = (i >= admcr_pkg::IDX_ATT_L) && (i <= admcr_pkg::IDX_CWSTAT);
  endfunction

  // write of one register byte, serial word or bus
  function automatic logic hit(input logic [6:0] i, input logic [6:0] want);
    hit = (i == want);
  endfunction

  // index decode and access-cycle write strobe, frozen by clk_en
  assign idx = word_index(req.paddr);
  assign wr_en = req.psel && req.penable && req.pwrite && clk_en;

  // control word: bit15 direction, bits14..8 index, bits7..0 data
  logic cw_wr;
  logic [6:0] cw_idx;
  logic [7:0] cw_data;
  logic any_wr;
  logic [6:0] w_idx;
  logic [7:0] w_data;
  assign cw_wr = wr_en && hit(idx, admcr_pkg::IDX_CWORD)
      && !pwdata[admcr_pkg::CW_DIR_BIT];
  assign cw_idx = pwdata[admcr_pkg::CW_IDX_HI:admcr_pkg::CW_IDX_LO];
  assign cw_data = pwdata[7:0];
  // direct bus writes reach only the writable indexes
  assign any_wr = cw_wr || (wr_en && mapped(idx) && idx <= admcr_pkg::IDX_ZERO);
  assign w_idx = cw_wr ? cw_idx : idx;
  assign w_data = cw_data;

  // input synchronisers for pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frm_sync_ff <= 3'h0;
      zl_sync_ff <= 2'h0;
      zr_sync_ff <= 2'h0;
    end
    else if (clk_en)
    begin
      frm_sync_ff <= {frm_sync_ff[1:0], frame_clk_pin};
      zl_sync_ff <= {zl_sync_ff[0], zero_left_pin};
      zr_sync_ff <= {zr_sync_ff[0], zero_right_pin};
    end
  end

  // raw attenuation codes as written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      att_l_ff <= admcr_pkg::RST_ATT;
      att_r_ff <= admcr_pkg::RST_ATT;
    end
    else if (any_wr)
    begin
      if (hit(w_idx, admcr_pkg::IDX_ATT_L))
        att_l_ff <= w_data;
      if (hit(w_idx, admcr_pkg::IDX_ATT_R))
        att_r_ff <= w_data;
    end
  end

  // targets load only while load enable set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tgt_l_ff <= admcr_pkg::RST_ATT;
      tgt_r_ff <= admcr_pkg::RST_ATT;
    end
    else if (any_wr && ctl_ff[admcr_pkg::F_LOAD])
    begin
      if (hit(w_idx, admcr_pkg::IDX_ATT_L))
        tgt_l_ff <= w_data;
      if (hit(w_idx, admcr_pkg::IDX_ATT_R))
        tgt_r_ff <= w_data;
    end
  end

  // mode registers; 22/23 have no write path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_ff <= admcr_pkg::RST_FMT;
      phase_ff <= admcr_pkg::RST_PHASE;
      mode_ff <= admcr_pkg::RST_MODE;
      zero_ff <= admcr_pkg::RST_ZERO;
    end
    else if (any_wr)
    begin
      if (hit(w_idx, admcr_pkg::IDX_FMT))
        ctl_ff <= w_data;
      if (hit(w_idx, admcr_pkg::IDX_PHASE))
        phase_ff <= w_data & admcr_pkg::MSK_PHASE;
      if (hit(w_idx, admcr_pkg::IDX_MODE))
        mode_ff <= w_data & admcr_pkg::MSK_MODE;
      if (hit(w_idx, admcr_pkg::IDX_ZERO))
        zero_ff <= w_data & admcr_pkg::MSK_ZERO;
    end
  end

  // control word shadow and its read-back result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cword_ff <= 16'h0000;
      cword_rd_ff <= 8'h00;
    end
    else if (wr_en && hit(idx, admcr_pkg::IDX_CWORD))
    begin
      cword_ff <= pwdata[15:0];
      if (pwdata[admcr_pkg::CW_DIR_BIT])
        cword_rd_ff <= reg_value(cw_idx);
    end
  end

  // register contents by index
  function automatic logic [7:0] reg_value(input logic [6:0] i);
    unique case (i)
      admcr_pkg::IDX_ATT_L: reg_value = att_l_ff;
      admcr_pkg::IDX_ATT_R: reg_value = att_r_ff;
      admcr_pkg::IDX_FMT: reg_value = ctl_ff;
      admcr_pkg::IDX_PHASE: reg_value = phase_ff;
      admcr_pkg::IDX_MODE: reg_value = mode_ff;
      admcr_pkg::IDX_ZERO: reg_value = zero_ff;
      admcr_pkg::IDX_ZFLAG: reg_value = {6'h00, zr_sync_ff[1], zl_sync_ff[1]};
      admcr_pkg::IDX_DEVNUM: reg_value = {3'h0, DEVICE_NUMBER};
      default: reg_value = 8'h00;
    endcase
  endfunction

  // frame step pacing, divided by 1,2,4,8
  logic frm_edge;
  logic [1:0] attenuation_step_rate;
  // rising frame edge seen after the two sync flops
  assign frm_edge = frm_sync_ff[1] && !frm_sync_ff[2];
  assign attenuation_step_rate = phase_ff[admcr_pkg::F_ATS_LO +: 2];
  assign step = frm_edge && (frm_cnt_ff == 3'h0);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frm_cnt_ff <= 3'h0;
    else if (clk_en && frm_edge)
    begin
      if (frm_cnt_ff == 3'h0)
        frm_cnt_ff <= 3'((4'h1 << attenuation_step_rate) - 4'h1);
      else
        frm_cnt_ff <= frm_cnt_ff - 3'h1;
    end
  end

  // soft mute ramp level, 255 steps from 255 down to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      smute_ff <= admcr_pkg::ATT_FULL;
    else if (clk_en && step)
    begin
      if (ctl_ff[admcr_pkg::F_MUTE] && smute_ff != 8'h00)
        smute_ff <= smute_ff - 8'h01;
      else if (!ctl_ff[admcr_pkg::F_MUTE] && smute_ff != admcr_pkg::ATT_FULL)
        smute_ff <= smute_ff + 8'h01;
    end
  end

  // applied levels walk one half-dB step per period
  function automatic logic [7:0] walk(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt)
      walk = cur + 8'h01;
    else if (cur > tgt)
      walk = cur - 8'h01;
    else
      walk = cur;
  endfunction

  // level registers move only on pacing strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_l_ff <= admcr_pkg::RST_ATT;
      lvl_r_ff <= admcr_pkg::RST_ATT;
    end
    else if (clk_en && step)
    begin
      lvl_l_ff <= walk(lvl_l_ff, tgt_l_ff);
      lvl_r_ff <= walk(lvl_r_ff, tgt_r_ff);
    end
  end

  // outputs: applied level is min of level and mute ramp
  logic [7:0] eff_l, eff_r;
  assign eff_l = (smute_ff < lvl_l_ff) ? smute_ff : lvl_l_ff;
  assign eff_r = (smute_ff < lvl_r_ff) ? smute_ff : lvl_r_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_applied_level <= admcr_pkg::RST_ATT;
      right_applied_level <= admcr_pkg::RST_ATT;
      left_full_mute <= 1'b0;
      right_full_mute <= 1'b0;
    end
    else if (clk_en)
    begin
      left_applied_level <= eff_l;
      right_applied_level <= eff_r;
      left_full_mute <= (eff_l <= admcr_pkg::ATT_MUTE_MAX);
      right_full_mute <= (eff_r <= admcr_pkg::ATT_MUTE_MAX);
    end
  end

  // decoded mode word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_out <= '0;
    else if (clk_en)
    begin
      mode_out.audio_format_select <= ctl_ff[admcr_pkg::F_FMT_LO +: 3];
      mode_out.one_bit_stream_mode <= mode_ff[admcr_pkg::F_DSD];
      mode_out.deemphasis_rate_select <= mode_ff[admcr_pkg::F_DSD] ? 2'b00
          : ctl_ff[admcr_pkg::F_DMF_LO +: 2];
      mode_out.fir_perf_select <= mode_ff[admcr_pkg::F_DSD]
          ? ctl_ff[admcr_pkg::F_DMF_LO +: 2] : 2'b00;
      mode_out.deemphasis_enable <= ctl_ff[admcr_pkg::F_DME];
      mode_out.soft_mute <= ctl_ff[admcr_pkg::F_MUTE];
      mode_out.output_polarity_invert <= phase_ff[admcr_pkg::F_REV];
    end
  end

  // apb read data and error, answered in access cycle
  always_comb
  begin
    nxt_prdata = admcr_pkg::RD_ZERO;
    nxt_err = 1'b0;
    if (hit(idx, admcr_pkg::IDX_CWORD))
      nxt_prdata = {16'h0000, cword_ff};
    else if (hit(idx, admcr_pkg::IDX_CWSTAT))
      nxt_prdata = {24'h000000, cword_rd_ff};
    else if (mapped(idx))
      nxt_prdata = {24'h000000, reg_value(idx)};
    else
      nxt_err = 1'b1;
  end

  // registered answer: setup cycle loads, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= admcr_pkg::RD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= req.psel && !req.penable;
      pslverr <= req.psel && !req.penable && nxt_err;
      if (req.psel && !req.penable && !req.pwrite)
        prdata <= nxt_prdata;
    end
  end
endmodule
`default_nettype wire

// File: shared/admcr_pkg.sv
package admcr_pkg;
  // register indexes (printed offsets are not multiples of four)
  localparam logic [6:0] IDX_ATT_L = 7'h10;
  localparam logic [6:0] IDX_ATT_R = 7'h11;
  localparam logic [6:0] IDX_FMT = 7'h12;
  localparam logic [6:0] IDX_PHASE = 7'h13;
  localparam logic [6:0] IDX_MODE = 7'h14;
  localparam logic [6:0] IDX_ZERO = 7'h15;
  localparam logic [6:0] IDX_ZFLAG = 7'h16;
  localparam logic [6:0] IDX_DEVNUM = 7'h17;
  // control word shadow register (serial control word entry)
  localparam logic [6:0] IDX_CWORD = 7'h18;
  localparam logic [6:0] IDX_CWSTAT = 7'h19;
  // control word layout
  localparam int CW_DIR_BIT = 15;
  localparam int CW_IDX_HI = 14;
  localparam int CW_IDX_LO = 8;
  // field positions
  localparam int F_LOAD = 7;
  localparam int F_FMT_LO = 4;
  localparam int F_DMF_LO = 2;
  localparam int F_DME = 1;
  localparam int F_MUTE = 0;
  localparam int F_REV = 7;
  localparam int F_ATS_LO = 5;
  localparam int F_DSD = 5;
  // reset values
  localparam logic [7:0] RST_ATT = 8'hFF;
  localparam logic [7:0] RST_FMT = 8'h50;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h01;
  // writable masks, reserved bits read zero
  localparam logic [7:0] MSK_PHASE = 8'hF7;
  localparam logic [7:0] MSK_MODE = 8'h3F;
  localparam logic [7:0] MSK_ZERO = 8'h07;
  localparam logic [7:0] ATT_MUTE_MAX = 8'h0E;
  localparam logic [7:0] ATT_FULL = 8'hFF;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // audio format codes
  typedef enum logic [2:0] {
    ADMCR_RJ16 = 3'b000,
    ADMCR_RJ20 = 3'b001,
    ADMCR_RJ24 = 3'b010,
    ADMCR_LJ24 = 3'b011,
    ADMCR_I2S16 = 3'b100,
    ADMCR_I2S24 = 3'b101,
    ADMCR_FMT_R6 = 3'b110,
    ADMCR_FMT_R7 = 3'b111
  } admcr_fmt_t;
  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } admcr_apb_req_t;
  // decoded mode outputs
  typedef struct packed {
    logic [2:0] audio_format_select;
    logic [1:0] deemphasis_rate_select;
    logic deemphasis_enable;
    logic [1:0] fir_perf_select;
    logic output_polarity_invert;
    logic soft_mute;
    logic one_bit_stream_mode;
  } admcr_mode_t;
endpackage

// File: test/admcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module admcr_host_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output var admcr_pkg::admcr_apb_req_t req
);
  // bus idle until the first transfer
  initial req = '0;
  // one transfer: setup, then access held until ready
  task automatic xfer(input logic wr, input logic [6:0] idx, input logic [15:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    req <= '{1'h1, 1'h0, wr, {idx[5:0], 2'h0}, {16'h0, d}};
    @(posedge pclk);
    req.penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask
endmodule
`default_nettype wire

// File: test/admcr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module admcr_regs_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_clk_pin,
  input wire logic [7:0] left_applied_level,
  input wire logic [7:0] right_applied_level,
  input wire logic left_full_mute,
  input wire logic right_full_mute,
  input wire admcr_pkg::admcr_mode_t mode_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_w = psel & penable & pready;
  logic [7:0] frm_age_ff;
  // cycles since the last frame clock rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frm_age_ff <= 8'hFF;
    else if ($rose(frame_clk_pin))
      frm_age_ff <= 8'h00;
    else if (frm_age_ff != 8'hFF)
      frm_age_ff <= frm_age_ff + 8'h01;
  end
  property p_fmt;
    logic [7:0] v;
    (acc_w && pwrite && paddr == 8'h48, v = pwdata[7:0]) |-> ##2
      mode_out.audio_format_select == v[6:4] && mode_out.deemphasis_enable == v[1] &&
      mode_out.soft_mute == v[0] &&
      (mode_out.one_bit_stream_mode || mode_out.deemphasis_rate_select == v[3:2]);
  endproperty
  property p_rev;
    logic v;
    (acc_w && pwrite && paddr == 8'h4C, v = pwdata[7]) |-> ##2
      mode_out.output_polarity_invert == v;
  endproperty
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_mute_left: assert property ($stable(left_applied_level) |->
    left_full_mute == (left_applied_level <= 8'h0E)) else $error("left mute flag wrong");
  chk_mute_right: assert property ($stable(right_applied_level) |->
    right_full_mute == (right_applied_level <= 8'h0E)) else $error("right mute flag wrong");
  chk_step_left: assert property ($changed(left_applied_level) |->
    8'(left_applied_level - $past(left_applied_level)) inside {8'h01, 8'hFF})
    else $error("left level jumped");
  chk_step_right: assert property ($changed(right_applied_level) |->
    8'(right_applied_level - $past(right_applied_level)) inside {8'h01, 8'hFF})
    else $error("right level jumped");
  chk_step_frame: assert property ($changed(left_applied_level) ||
    $changed(right_applied_level) |-> frm_age_ff <= 8'h06) else $error("step off frame");
  chk_mode_write: assert property (p_fmt)
    else $error("mode fields not applied");
  chk_phase_write: assert property (p_rev)
    else $error("polarity not applied");
  chk_id_read: assert property (acc_w && !pwrite && paddr == 8'h5C |->
    prdata[31:5] == 27'h0) else $error("id reserved bits set");
  cover property (acc_w && pslverr);
  cover property ($rose(left_full_mute));
  cover property (mode_out.soft_mute && right_applied_level == 8'h00);
endmodule
bind admcr_regs admcr_regs_checker #(.ADDR_W(ADDR_W)) chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_clk_pin,
  .left_applied_level, .right_applied_level, .left_full_mute, .right_full_mute, .mode_out);
`default_nettype wire

// File: test/admcr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module admcr_regs_tb_top;
  localparam logic [4:0] DEV_NUM = 5'h0B; // arbitrary value
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic frame_clk_pin = 1'h0;
  logic [2:0] frm_cnt_ff = 3'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, left_full_mute, right_full_mute;
  logic [7:0] left_applied_level, right_applied_level;
  admcr_pkg::admcr_mode_t mode_out;
  admcr_pkg::admcr_apb_req_t req;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  admcr_host_model host_u (.pclk, .prdata, .pready, .pslverr, .req);
  admcr_regs #(.DEVICE_NUMBER(DEV_NUM)) dut_u (.pclk, .presetn, .clk_en(1'h1),
    .psel(req.psel), .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
    .pwdata(req.pwdata), .prdata, .pready, .pslverr, .frame_clk_pin,
    .zero_left_pin(1'h1), .zero_right_pin(1'h0), .left_applied_level,
    .right_applied_level, .left_full_mute, .right_full_mute, .mode_out);
  // clock, frame clock of 16 cycles, run limit
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    frm_cnt_ff <= frm_cnt_ff + 3'h1;
    if (frm_cnt_ff == 3'h7)
      frame_clk_pin <= ~frame_clk_pin;
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("unexpected %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [6:0] i, input logic [15:0] d);
    host_u.xfer(1'h1, i, d, q, e);
  endtask
  task automatic rd(input logic [6:0] i, input logic [31:0] x);
    host_u.xfer(1'h0, i, 16'h0, q, e);
    chk(q, x);
  endtask
  // wait for both applied levels, count cycles
  task automatic wait_lvl(input logic [7:0] l, input logic [7:0] r, output int n);
    n = 0;
    while (!(left_applied_level === l && right_applied_level === r) && n < 9000)
    begin
      @(negedge pclk);
      n++;
    end
  endtask
  // register sequence
  initial
  begin
    int n;
    logic [7:0] v;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rd(7'h10, 32'hFF);
    rd(7'h11, 32'hFF);
    rd(7'h12, 32'h50);
    chk(mode_out.audio_format_select, 32'h5);
    rd(7'h16, 32'h01);
    wr(7'h16, 16'h00FE);
    rd(7'h16, 32'h01);
    wr(7'h17, 16'h00FF);
    rd(7'h17, {27'h0, DEV_NUM});
    host_u.xfer(1'h0, 7'h30, 16'h0, q, e);
    chk(e, 32'h1);
    chk(q, 32'h0);
    wr(7'h13, 16'h00FF);
    rd(7'h13, 32'hF7);
    wr(7'h13, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      v = {1'h0, i[2:0], i[1:0], i[0], 1'h0};
      wr(7'h12, {8'h0, v});
      rd(7'h12, {24'h0, v});
      chk(mode_out.audio_format_select, i[2:0]);
      chk(mode_out.deemphasis_rate_select, i[1:0]);
      chk(mode_out.deemphasis_enable, i[0]);
    end
    wr(7'h14, 16'h0020);
    repeat (2) @(posedge pclk);
    chk(mode_out.one_bit_stream_mode, 32'h1);
    chk(mode_out.fir_perf_select, 32'h3);
    chk(mode_out.deemphasis_rate_select, 32'h0);
    wr(7'h14, 16'h0000);
    wr(7'h12, 16'h0050);
    wr(7'h10, 16'h0020);
    repeat (64) @(posedge pclk);
    chk(left_applied_level, 32'hFF);
    rd(7'h10, 32'h20);
    wr(7'h12, 16'h00D0);
    wr(7'h10, 16'h000A);
    wr(7'h11, 16'h000F);
    wait_lvl(8'h0A, 8'h0F, n);
    chk(n > 3800 && n < 4300, 32'h1);
    chk(left_full_mute, 32'h1);
    chk(right_full_mute, 32'h0);
    wr(7'h13, 16'h0060);
    wr(7'h10, 16'h000E);
    wait_lvl(8'h0E, 8'h0F, n);
    chk(n > 380 && n < 640, 32'h1);
    chk(left_full_mute, 32'h1);
    wr(7'h13, 16'h0000);
    wr(7'h12, 16'h00D1);
    wait_lvl(8'h00, 8'h00, n);
    chk(n > 4000 && n < 4200, 32'h1);
    chk(right_full_mute, 32'h1);
    wr(7'h18, 16'h1380);
    rd(7'h13, 32'h80);
    chk(mode_out.output_polarity_invert, 32'h1);
    wr(7'h18, 16'h9100);
    rd(7'h19, 32'h0F);
    close_out();
  end
endmodule
`default_nettype wire
